// ==== rcw_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcw_chk #(
  parameter int POR_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_in,
  input wire logic reset_pin_oe,
  input wire rcw_pkg::rcw_mode_type mode_pins,
  input wire logic watchdog_disable_bit,
  input wire logic rom_enable,
  input wire logic clock_fail_detect,
  input wire logic system_reset,
  input wire rcw_pkg::rcw_vector_type reset_vector
);
  import rcw_pkg::*;
  int por_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt <= 0;
    end else if (por_cnt < POR_CYCLES) begin
      por_cnt <= por_cnt + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rel_s;
    system_reset && $fell(reset_pin_oe);
  endsequence
  drive_four_a: assert property (
    $rose(reset_pin_oe) |-> reset_pin_oe [*4] ##1 !reset_pin_oe)
    else $error("pin drive length wrong");
  int_release_a: assert property (
    rel_s ##1 reset_pin_in [*2] |-> ##[0:1] !system_reset)
    else $error("internal reset not ended");
  ext_hold_a: assert property (
    rel_s ##1 !reset_pin_in [*2] |-> system_reset)
    else $error("external reset ended early");
  por_hold_a: assert property (
    por_cnt < POR_CYCLES |-> reset_pin_oe && system_reset)
    else $error("power-on hold too short");
  vec_area_a: assert property (
    !system_reset |-> reset_vector.addr[15:4] ==
      {mode_pins.mode_b ? 8'hff : 8'hbf, 4'hf})
    else $error("vector area wrong");
  vec_code_a: assert property (
    !system_reset |-> reset_vector.addr[3:0] inside {4'ha, 4'hc, 4'he})
    else $error("vector code wrong");
  vec_src_a: assert property (
    $fell(system_reset) && reset_vector.addr[3:0] == 4'he |->
      reset_vector.source == (mode_pins.mode_b ?
      (rom_enable ? RCW_SRC_INT_ROM : RCW_SRC_EXTERNAL) :
      (mode_pins.mode_a ? RCW_SRC_EXTERNAL : RCW_SRC_BOOT_ROM)))
    else $error("vector source wrong");
  wd_off_a: assert property (
    !system_reset && watchdog_disable_bit && !clock_fail_detect &&
      reset_pin_in |=> !reset_pin_oe)
    else $error("disabled watchdog reset");
  cover property (rel_s ##1 reset_pin_in [*2]);
  cover property (rel_s ##1 !reset_pin_in [*2]);
  cover property ($fell(system_reset));
endmodule // rcw_chk
bind rcw_reset_watchdog rcw_chk #(.POR_CYCLES(POR_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .reset_pin_in(reset_pin_in),
  .reset_pin_oe(reset_pin_oe), .mode_pins(mode_pins),
  .watchdog_disable_bit(watchdog_disable_bit), .rom_enable(rom_enable),
  .clock_fail_detect(clock_fail_detect), .system_reset(system_reset),
  .reset_vector(reset_vector));
`default_nettype wire

// ==== rcw_ext_reset.sv ====
`timescale 1ns/1ns
`default_nettype none
module rcw_ext_reset (
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic ext_low,
  output logic reset_pin_in
);
  // open-drain wire, pull-up wins once both drivers let go
  assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) &&
    !ext_low;
endmodule // rcw_ext_reset
`default_nettype wire

// ==== rcw_params.svh ====
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH

// register byte offsets
`define RCW_CTRL_OFS 8'h00
`define RCW_SERVICE_OFS 8'h04
`define RCW_STATUS_OFS 8'h08
`define RCW_VECTOR_OFS 8'h0c
`define RCW_COUNT_OFS 8'h10

// control register fields
`define RCW_CTRL_RATE_LSB 0
`define RCW_CTRL_CME_BIT 2
`define RCW_CTRL_INHIBIT_BIT 3

// status register fields
`define RCW_STAT_CM_BIT 0
`define RCW_STAT_WD_BIT 1
`define RCW_STAT_EXT_BIT 2
`define RCW_STAT_WDEN_BIT 3
`define RCW_STAT_MODE_LSB 4
`define RCW_STAT_LOCK_BIT 6
`define RCW_STAT_ARMED_BIT 7

// vector register fields
`define RCW_VEC_SRC_LSB 16

// service key values
`define RCW_KEY_ARM 8'h55
`define RCW_KEY_CLEAR 8'haa

// vector addresses (high byte of each pair)
`define RCW_VEC_NORMAL_BASE 16'hfffe
`define RCW_VEC_SPECIAL_BASE 16'hbffe
`define RCW_VEC_CM_STEP 16'h0002
`define RCW_VEC_WD_STEP 16'h0004

// timing: clock period in ns, times and derived cycle counts
`define RCW_CLK_PERIOD_NS 100
`define RCW_POR_CYCLES 4064
`define RCW_DRIVE_CYCLES 4
`define RCW_SAMPLE_DELAY_CYCLES 2
`define RCW_RATE_WINDOW_CYCLES 64
`define RCW_PRESCALE_BITS 15

// reset values
`define RCW_CTRL_RESET 4'h0

`endif

// ==== rcw_pkg.sv ====
package rcw_pkg;

  typedef enum logic [2:0] {
    RCW_ST_POR = 3'b000,
    RCW_ST_RUN = 3'b001,
    RCW_ST_DRIVE = 3'b010,
    RCW_ST_RELEASE = 3'b011,
    RCW_ST_EXT_WAIT = 3'b100
  } rcw_state_type;

  typedef enum logic [1:0] {
    RCW_SRC_INT_ROM = 2'b00,
    RCW_SRC_EXTERNAL = 2'b01,
    RCW_SRC_BOOT_ROM = 2'b10
  } rcw_source_type;

  typedef struct packed {
    logic clock_fail;
    logic watchdog;
  } rcw_cause_type;

  typedef struct packed {
    logic [15:0] addr;
    rcw_source_type source;
  } rcw_vector_type;

  // mode pins: {mode_b, mode_a}
  typedef struct packed {
    logic mode_b;
    logic mode_a;
  } rcw_mode_type;

endpackage

// ==== rcw_reset_watchdog.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rcw_params.svh"

module rcw_reset_watchdog #(
  parameter int POR_CYCLES = `RCW_POR_CYCLES,
  parameter int PRESCALE_BITS = `RCW_PRESCALE_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire rcw_pkg::rcw_mode_type mode_pins,
  input wire logic watchdog_disable_bit,
  input wire logic rom_enable,
  input wire logic clock_fail_detect,
  output logic system_reset,
  output rcw_pkg::rcw_vector_type reset_vector
);
  import rcw_pkg::*;

  localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);
  localparam logic [11:0] DRIVE_LAST = 12'(`RCW_DRIVE_CYCLES - 1);
  localparam logic [11:0] SAMPLE_LAST = 12'(`RCW_SAMPLE_DELAY_CYCLES - 1);
  localparam logic [6:0] RATE_WINDOW = 7'(`RCW_RATE_WINDOW_CYCLES);

  // last count of the rate stage for each rate setting
  function automatic logic [5:0] rate_last(input logic [1:0] rate);
    case (rate)
      2'b00: rate_last = 6'h00;
      2'b01: rate_last = 6'h03;
      2'b10: rate_last = 6'h0f;
      default: rate_last = 6'h3f;
    endcase
  endfunction

  function automatic rcw_vector_type pick_vector(
    input rcw_cause_type cause,
    input rcw_mode_type mode,
    input logic rom_on
  );
    logic [15:0] base;
    logic [15:0] step;
    logic is_reset;
    base = mode.mode_b ? `RCW_VEC_NORMAL_BASE : `RCW_VEC_SPECIAL_BASE;
    step = 16'h0000;
    if (cause.clock_fail) begin
      step = `RCW_VEC_CM_STEP;
    end else if (cause.watchdog) begin
      step = `RCW_VEC_WD_STEP;
    end
    is_reset = (step == 16'h0000);
    pick_vector.addr = base - step;
    if (mode.mode_b) begin
      pick_vector.source = rom_on ? RCW_SRC_INT_ROM : RCW_SRC_EXTERNAL;
    end else if (mode.mode_a) begin
      pick_vector.source = RCW_SRC_EXTERNAL;
    end else begin
      pick_vector.source = RCW_SRC_BOOT_ROM;
    end
    if (!is_reset && mode.mode_b && !rom_on) begin
      pick_vector.source = RCW_SRC_EXTERNAL;
    end
  endfunction

  rcw_state_type state;
  rcw_state_type next_state;
  logic [11:0] seq_cnt;
  rcw_cause_type cause;
  logic ext_cause;
  rcw_mode_type mode;
  logic wd_enabled;
  logic [1:0] rate;
  logic clock_monitor_enable_bit;
  logic inhibit;
  logic rate_locked;
  logic [6:0] window_cnt;
  logic armed;
  logic [PRESCALE_BITS-1:0] prescale;
  logic [5:0] stage;
  logic tick;
  logic wd_timeout;
  logic cm_trigger;
  logic internal_trigger;
  logic releasing;
  logic wr_en;
  logic wr_ctrl;
  logic wr_service;
  logic in_run;
  logic mapped;
  logic [31:0] read_mux;

  assign in_run = (state == RCW_ST_RUN);
  assign releasing = !in_run && (next_state == RCW_ST_RUN);
  assign wr_en = psel && penable && pready && pwrite && in_run;
  assign wr_ctrl = wr_en && (paddr == `RCW_CTRL_OFS);
  assign wr_service = wr_en && (paddr == `RCW_SERVICE_OFS);
  assign tick = (prescale == {PRESCALE_BITS{1'b1}});
  assign wd_timeout = tick && (stage == rate_last(rate));
  assign cm_trigger = clock_monitor_enable_bit && clock_fail_detect && !inhibit;
  // inhibit also masks the clock monitor, as in special modes both are off
  assign internal_trigger = (wd_timeout && wd_enabled && !inhibit) ||
    cm_trigger;

  // reset sequencer
  always_comb begin
    next_state = state;
    case (state)
      RCW_ST_POR: begin
        if (seq_cnt == POR_LAST) begin
          next_state = RCW_ST_RUN;
        end
      end
      RCW_ST_RUN: begin
        if (!reset_pin_in || internal_trigger) begin
          next_state = RCW_ST_DRIVE;
        end
      end
      RCW_ST_DRIVE: begin
        if (seq_cnt == DRIVE_LAST) begin
          next_state = RCW_ST_RELEASE;
        end
      end
      RCW_ST_RELEASE: begin
        if (seq_cnt == SAMPLE_LAST) begin
          next_state = reset_pin_in ? RCW_ST_RUN : RCW_ST_EXT_WAIT;
        end
      end
      RCW_ST_EXT_WAIT: begin
        if (reset_pin_in) begin
          next_state = RCW_ST_RUN;
        end
      end
      default: next_state = RCW_ST_POR;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RCW_ST_POR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt <= 12'h000;
    end else if (next_state != state) begin
      seq_cnt <= 12'h000;
    end else if (!in_run && state != RCW_ST_EXT_WAIT) begin
      seq_cnt <= seq_cnt + 12'h001;
    end
  end

  // pin driver: low while counting power-on or the fixed drive phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_oe <= 1'b1;
      reset_pin_out <= 1'b0;
      system_reset <= 1'b1;
    end else begin
      reset_pin_oe <= (next_state == RCW_ST_POR) ||
        (next_state == RCW_ST_DRIVE);
      reset_pin_out <= 1'b0;
      system_reset <= (next_state != RCW_ST_RUN);
    end
  end

  // cause latch and discrimination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= '0;
      ext_cause <= 1'b0;
    end else if (in_run && next_state == RCW_ST_DRIVE) begin
      cause.clock_fail <= cm_trigger;
      cause.watchdog <= wd_timeout && wd_enabled && !inhibit;
      // external only once the late sample still sees the pin low
      ext_cause <= 1'b0;
    end else if (state == RCW_ST_RELEASE &&
      seq_cnt == SAMPLE_LAST && !reset_pin_in) begin
      // a short external pulse can look internal; latch decides vector
      cause <= '0;
      ext_cause <= 1'b1;
    end
  end

  // mode, watchdog enable and vector are settled as reset releases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= '0;
      wd_enabled <= 1'b0;
      reset_vector <= '0;
    end else if (releasing) begin
      mode <= mode_pins;
      wd_enabled <= !watchdog_disable_bit;
      reset_vector <= pick_vector(
        (state == RCW_ST_POR || state == RCW_ST_EXT_WAIT) ? '0 : cause,
        mode_pins, rom_enable);
    end
  end

  // control register; rate and clock monitor enable cleared by every reset sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate <= 2'b00;
      clock_monitor_enable_bit <= 1'b0;
    end else if (!in_run) begin
      rate <= 2'b00;
      clock_monitor_enable_bit <= 1'b0;
    end else if (wr_ctrl) begin
      clock_monitor_enable_bit <= pwdata[`RCW_CTRL_CME_BIT];
      if (!mode.mode_b || (!rate_locked && window_cnt < RATE_WINDOW)) begin
        rate <= pwdata[`RCW_CTRL_RATE_LSB +: 2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit <= 1'b0;
    end else if (releasing) begin
      inhibit <= !mode_pins.mode_b;
    end else if (!mode.mode_b && wr_ctrl) begin
      // only clearing is honoured; once cleared it stays cleared
      inhibit <= inhibit && pwdata[`RCW_CTRL_INHIBIT_BIT];
    end else if (mode.mode_b) begin
      inhibit <= 1'b0;
    end
  end

  // rate write window after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_cnt <= 7'h00;
      rate_locked <= 1'b0;
    end else if (!in_run) begin
      window_cnt <= 7'h00;
      rate_locked <= 1'b0;
    end else begin
      if (window_cnt < RATE_WINDOW) begin
        window_cnt <= window_cnt + 7'h01;
      end
      if (wr_ctrl && mode.mode_b) begin
        rate_locked <= 1'b1;
      end
    end
  end

  // service key sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (!in_run) begin
      armed <= 1'b0;
    end else if (wr_service) begin
      if (pwdata[7:0] == `RCW_KEY_ARM) begin
        armed <= 1'b1;
      end else if (pwdata[7:0] == `RCW_KEY_CLEAR) begin
        armed <= 1'b0;
      end
    end
  end

  // free-running prescaler; only a reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= '0;
    end else if (!in_run) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // rate stage; service clears it, prescaler keeps running (-1/+0 tick)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage <= 6'h00;
    end else if (!in_run) begin
      stage <= 6'h00;
    end else if (wr_service && armed &&
      pwdata[7:0] == `RCW_KEY_CLEAR) begin
      stage <= 6'h00;
    end else if (tick) begin
      stage <= wd_timeout ? 6'h00 : stage + 6'h01;
    end
  end

  // apb read path
  always_comb begin
    mapped = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      `RCW_CTRL_OFS: begin
        read_mux[`RCW_CTRL_RATE_LSB +: 2] = rate;
        read_mux[`RCW_CTRL_CME_BIT] = clock_monitor_enable_bit;
        read_mux[`RCW_CTRL_INHIBIT_BIT] = inhibit;
      end
      `RCW_SERVICE_OFS: read_mux = 32'h0000_0000;
      `RCW_STATUS_OFS: begin
        read_mux[`RCW_STAT_CM_BIT] = cause.clock_fail;
        read_mux[`RCW_STAT_WD_BIT] = cause.watchdog;
        read_mux[`RCW_STAT_EXT_BIT] = ext_cause;
        read_mux[`RCW_STAT_WDEN_BIT] = wd_enabled;
        read_mux[`RCW_STAT_MODE_LSB +: 2] = mode;
        read_mux[`RCW_STAT_LOCK_BIT] = rate_locked;
        read_mux[`RCW_STAT_ARMED_BIT] = armed;
      end
      `RCW_VECTOR_OFS: begin
        read_mux[15:0] = reset_vector.addr;
        read_mux[`RCW_VEC_SRC_LSB +: 2] = reset_vector.source;
      end
      `RCW_COUNT_OFS: begin
        read_mux[5:0] = stage;
        read_mux[6 +: PRESCALE_BITS] = prescale;
      end
      default: mapped = 1'b0;
    endcase
  end

  // no wait states: answer is registered in setup and ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : read_mux;
        pslverr <= !mapped;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // rcw_reset_watchdog
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rcw_params.svh"
module tb;
  import rcw_pkg::*;
  localparam int TICK = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, dis, rom, cfail, ext_low;
  logic pready, pslverr, oe, sysr, pin, er, pout;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  rcw_mode_type mode;
  rcw_vector_type vec;
  int err_count = 0;
  int comparisons = 0;
  int n, lo, hi, t_prev, t_now;
  int cyc = 0;
  rcw_mode_type modes [3] = '{2'h2, 2'h1, 2'h0};
  rcw_source_type srcs [3] = '{RCW_SRC_EXTERNAL, RCW_SRC_EXTERNAL,
    RCW_SRC_BOOT_ROM};
  logic [15:0] bases [3] = '{16'hfffe, 16'hbffe, 16'hbffe};
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  rcw_reset_watchdog #(.POR_CYCLES(16), .PRESCALE_BITS(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_in(pin),
    .reset_pin_out(pout), .reset_pin_oe(oe), .mode_pins(mode),
    .watchdog_disable_bit(dis), .rom_enable(rom),
    .clock_fail_detect(cfail), .system_reset(sysr), .reset_vector(vec));
  rcw_ext_reset u_ext (.reset_pin_oe(oe), .reset_pin_out(pout),
    .ext_low(ext_low), .reset_pin_in(pin));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk("register", e, rv & m);
  endtask
  task automatic wait_for(logic v);
    n = 0;
    while (sysr !== v && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    // span between two waits is measured in whole clock edges
    t_prev = t_now;
    t_now = cyc;
    if (sysr !== v) begin
      err_count++;
      $display("CHECK FAILED system_reset expected %b seen %b", v, sysr);
    end
  endtask
  task automatic boot(rcw_mode_type m, logic r, logic d);
    presetn <= 1'b0;
    mode <= m;
    rom <= r;
    dis <= d;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_for(1'b0);
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, cfail, ext_low} = 5'h00;
    {dis, rom} = 2'h3;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mode = 2'h3;
    @(posedge pclk);
    boot(2'h3, 1'b1, 1'b1);
    rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0000_fffe);
    rdc(`RCW_CTRL_OFS, 32'h0000_000f, 32'h0000_0000);
    rdc(`RCW_STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
    xfer(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, er});
    xfer(1'b1, `RCW_CTRL_OFS, 32'h0000_000a);
    rdc(`RCW_CTRL_OFS, 32'h0000_000b, 32'h0000_0002);
    xfer(1'b1, `RCW_CTRL_OFS, 32'h0000_0005);
    rdc(`RCW_CTRL_OFS, 32'h0000_0007, 32'h0000_0006);
    cfail <= 1'b1;
    wait_for(1'b1);
    cfail <= 1'b0;
    wait_for(1'b0);
    rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0000_fffc);
    rdc(`RCW_STATUS_OFS, 32'h0000_0007, 32'h0000_0001);
    ext_low <= 1'b1;
    wait_for(1'b1);
    repeat (12) @(posedge pclk);
    ext_low <= 1'b0;
    wait_for(1'b0);
    rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0000_fffe);
    rdc(`RCW_STATUS_OFS, 32'h0000_0007, 32'h0000_0004);
    // too short on purpose: must fall back to the normal vector
    ext_low <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_low <= 1'b0;
    wait_for(1'b0);
    rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0000_fffe);
    rdc(`RCW_STATUS_OFS, 32'h0000_0007, 32'h0000_0000);
    boot(2'h3, 1'b1, 1'b0);
    rdc(`RCW_STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
    for (int r = 0; r < 4; r++) begin
      rdc(`RCW_CTRL_OFS, 32'h0000_0003, 32'h0000_0000);
      xfer(1'b1, `RCW_CTRL_OFS, r);
      wait_for(1'b1);
      // timer restarts at release, not at the rate write
      lo = TICK << (2 * r);
      hi = lo + TICK;
      n = t_now - t_prev;
      chk("timeout span", lo, (n >= lo && n <= hi) ? lo : n);
      wait_for(1'b0);
      rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0000_fffa);
      rdc(`RCW_STATUS_OFS, 32'h0000_0007, 32'h0000_0002);
    end
    xfer(1'b1, `RCW_CTRL_OFS, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    xfer(1'b1, `RCW_SERVICE_OFS, 32'h0000_0055);
    xfer(1'b1, `RCW_SERVICE_OFS, 32'h0000_00aa);
    rdc(`RCW_COUNT_OFS, 32'h0000_003f, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    chk("serviced", 32'h0, {31'h0, sysr});
    xfer(1'b1, `RCW_CTRL_OFS, 32'h0000_0003);
    rdc(`RCW_CTRL_OFS, 32'h0000_0003, 32'h0000_0001);
    wait_for(1'b1);
    wait_for(1'b0);
    for (int i = 0; i < 3; i++) begin
      boot(modes[i], i != 0, 1'b0);
      rdc(`RCW_VECTOR_OFS, 32'h3_ffff, {14'h0, srcs[i], bases[i]});
    end
    rdc(`RCW_CTRL_OFS, 32'h0000_0008, 32'h0000_0008);
    repeat (60) @(posedge pclk);
    chk("inhibited", 32'h0, {31'h0, sysr});
    xfer(1'b1, `RCW_CTRL_OFS, 32'h0000_0000);
    wait_for(1'b1);
    wait_for(1'b0);
    rdc(`RCW_VECTOR_OFS, 32'h3_ffff, 32'h0002_bffa);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
